/* File: design/afs_regs.sv */
`timescale 1ns/1ns
`include "afs_map.svh"

// Notes on behaviour
// - slave address is 11011, two strap bits, then read/write bit
// - offsets 0x00-0x07 are read-only; writes leave them unchanged
// - offsets 0x08-0x0D and 0x10 are writable controls; 0x08 holds gains
// - 0x0E, 0x0F unused; 0x13 reads thermal shutdown and foldback status
// - protection latch bits 0-3: temp warn, dc any, overcurrent any, temp off
// - protection latch bits 4-7: pump uv, analog uv, stage uv, stage ov
// - channel latch bits 0-3 record overcurrent shutdown, channels 1-4
// - channel latch bits 4-7 record dc offset, channels 1-4
// - diag latch A bits 0-3: channel 1 gnd, supply, shorted, open
// - diag latch A bits 4-7: channel 2, open load in bit 7
// - diag latch B bits 0-3: channel 3 gnd, supply, shorted, open
// - diag latch B bits 4-7: channel 4, open load in bit 7
// - live register bits 0-4 show present faults, not latched
// - live bits 7-5 encode warning 001, 011, 101, 111
// - registers 0x00-0x04 read zero after power-up
// - each written data byte acked, pointer advances by one
// - slave only, up to 400 kbps, never holds the clock line
// - address strap also selects oscillator leader or follower role
module afs_regs (
    // system
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // serial bus and strap
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [1:0]  addr_sel_i,
    output logic [1:0]       osc_role_o,
    // fault events, one bit per cause
    input  wire logic [7:0]  prot_evt_i,
    input  wire logic [7:0]  chan_evt_i,
    input  wire logic [7:0]  diag_a_evt_i,
    input  wire logic [7:0]  diag_b_evt_i,
    // live status
    input  wire logic [4:0]  live_fault_i,
    input  wire logic [2:0]  otw_level_i,
    input  wire logic [7:0]  out_state_i,
    input  wire logic [7:0]  play_mute_i,
    input  wire logic [7:0]  diag_mode_i,
    input  wire logic [7:0]  thermal_i,
    // control registers
    output logic [7:0]       gain_ctl_o,
    output logic [7:0]       ocp_ctl_o,
    output logic [7:0]       fsw_ctl_o,
    output logic [7:0]       diag_ctl_o,
    output logic [7:0]       out_ctl_a_o,
    output logic [7:0]       out_ctl_b_o,
    output logic [7:0]       dc_thr_o,
    output logic             fault_clr_o
);

    afs_pkg::afs_st_t r_r;
    afs_pkg::afs_st_t r_nxt;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_cond;
    logic             stop_cond;
    logic             wr_commit;
    logic             clr_pulse;
    logic [7:0]       live_byte;
    logic [7:0]       rd_byte;

    // map a 0-4 temperature level to the three-bit warning code
    function automatic logic [2:0] afs_otw_code(input logic [2:0] lvl);
        case (lvl)
            3'h1:    afs_otw_code = `AFS_OTW_WARN;
            3'h2:    afs_otw_code = `AFS_OTW_LVL1;
            3'h3:    afs_otw_code = `AFS_OTW_LVL2;
            3'h4:    afs_otw_code = `AFS_OTW_LVL3;
            default: afs_otw_code = `AFS_OTW_NONE;
        endcase
    endfunction : afs_otw_code

    // control slot for an offset, 7 when not writable
    function automatic logic [2:0] afs_ctl_idx(input logic [7:0] a);
        case (a)
            `AFS_OFF_GAIN:     afs_ctl_idx = 3'h0;
            `AFS_OFF_OCP:      afs_ctl_idx = 3'h1;
            `AFS_OFF_FSW:      afs_ctl_idx = 3'h2;
            `AFS_OFF_DIAGCTL:  afs_ctl_idx = 3'h3;
            `AFS_OFF_OUTCTL_A: afs_ctl_idx = 3'h4;
            `AFS_OFF_OUTCTL_B: afs_ctl_idx = 3'h5;
            `AFS_OFF_DCTHR:    afs_ctl_idx = 3'h6;
            default:           afs_ctl_idx = 3'h7;
        endcase
    endfunction : afs_ctl_idx

    assign live_byte = {afs_otw_code(otw_level_i), live_fault_i};

    always_comb begin
        case (r_r.ptr)
            `AFS_OFF_LAT_PROT: rd_byte = r_r.lat[0];
            `AFS_OFF_LAT_CHAN: rd_byte = r_r.lat[1];
            `AFS_OFF_DIAG_A:   rd_byte = r_r.lat[2];
            `AFS_OFF_DIAG_B:   rd_byte = r_r.lat[3];
            `AFS_OFF_LIVE:     rd_byte = live_byte;
            `AFS_OFF_OUTST:    rd_byte = out_state_i;
            `AFS_OFF_PLAY:     rd_byte = play_mute_i;
            `AFS_OFF_DMODE:    rd_byte = diag_mode_i;
            `AFS_OFF_THERM:    rd_byte = thermal_i;
            default: begin
                // unused offsets, 0x0e and 0x0f among them, read zero
                if (afs_ctl_idx(r_r.ptr) != 3'h7) begin
                    rd_byte = r_r.ctl[afs_ctl_idx(r_r.ptr)];
                end else begin
                    rd_byte = 8'h00;
                end
            end
        endcase
    end

    assign scl_rise   = scl_i & ~r_r.scl_q;
    assign scl_fall   = ~scl_i & r_r.scl_q;
    assign start_cond = scl_i & r_r.scl_q & r_r.sda_q & ~sda_i;
    assign stop_cond  = scl_i & r_r.scl_q & ~r_r.sda_q & sda_i;
    assign wr_commit  = (r_r.st == afs_pkg::AFS_WDATA) & scl_fall
                        & (r_r.cnt == 4'h8);
    // fault clear acts on the write itself, not on a stored bit
    assign clr_pulse  = wr_commit & (r_r.ptr == `AFS_OFF_OUTCTL_B)
                        & r_r.shreg[`AFS_FAULT_CLR_BIT];

    always_comb begin
        r_nxt       = r_r;
        r_nxt.scl_q = scl_i;
        r_nxt.sda_q = sda_i;
        if (!r_r.strap_ok) begin
            r_nxt.strap    = addr_sel_i;
            r_nxt.strap_ok = 1'b1;
        end
        // set wins over a clear in the same cycle
        r_nxt.lat[0] = (r_r.lat[0] & ~{8{clr_pulse}}) | prot_evt_i
                       | {5'h00, |chan_evt_i[3:0], |chan_evt_i[7:4], 1'b0};
        r_nxt.lat[1] = (r_r.lat[1] & ~{8{clr_pulse}}) | chan_evt_i;
        r_nxt.lat[2] = (r_r.lat[2] & ~{8{clr_pulse}})
                       | diag_a_evt_i;
        r_nxt.lat[3] = (r_r.lat[3] & ~{8{clr_pulse}})
                       | diag_b_evt_i;

        if (start_cond) begin
            r_nxt.st  = afs_pkg::AFS_ADDR;
            r_nxt.cnt = 4'h0;
            r_nxt.oe  = 1'b0;
        end else if (stop_cond) begin
            r_nxt.st = afs_pkg::AFS_IDLE;
            r_nxt.oe = 1'b0;
        end else begin
            case (r_r.st)
                afs_pkg::AFS_IDLE: begin
                    r_nxt.oe = 1'b0;
                end
                afs_pkg::AFS_ADDR,
                afs_pkg::AFS_SUB,
                afs_pkg::AFS_WDATA: begin
                    if (scl_rise && r_r.cnt != 4'h8) begin
                        r_nxt.shreg = {r_r.shreg[6:0], sda_i};
                        r_nxt.cnt   = r_r.cnt + 4'h1;
                    end else if (scl_fall && r_r.cnt == 4'h8) begin
                        r_nxt.cnt = 4'h0;
                        if (r_r.st == afs_pkg::AFS_ADDR) begin
                            if (r_r.shreg[7:1] ==
                                {`AFS_ADDR_PREFIX, r_r.strap}) begin
                                r_nxt.rw = r_r.shreg[0];
                                r_nxt.oe = 1'b1;
                                r_nxt.st = afs_pkg::AFS_ACK_ADDR;
                            end else begin
                                r_nxt.st = afs_pkg::AFS_IDLE;
                            end
                        end else if (r_r.st == afs_pkg::AFS_SUB) begin
                            r_nxt.ptr = r_r.shreg;
                            r_nxt.oe  = 1'b1;
                            r_nxt.st  = afs_pkg::AFS_ACK_SUB;
                        end else begin
                            // read-only offsets take no write
                            if (afs_ctl_idx(r_r.ptr) != 3'h7) begin
                                r_nxt.ctl[afs_ctl_idx(r_r.ptr)] = r_r.shreg;
                            end
                            r_nxt.ptr = r_r.ptr + 8'h01;
                            r_nxt.oe  = 1'b1;
                            r_nxt.st  = afs_pkg::AFS_ACK_WR;
                        end
                    end
                end
                afs_pkg::AFS_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (r_r.rw) begin
                            r_nxt.shreg = rd_byte;
                            r_nxt.ptr   = r_r.ptr + 8'h01;
                            r_nxt.oe    = ~rd_byte[7];
                            r_nxt.st    = afs_pkg::AFS_RDATA;
                        end else begin
                            r_nxt.oe = 1'b0;
                            r_nxt.st = afs_pkg::AFS_SUB;
                        end
                    end
                end
                afs_pkg::AFS_ACK_SUB,
                afs_pkg::AFS_ACK_WR: begin
                    if (scl_fall) begin
                        r_nxt.oe = 1'b0;
                        r_nxt.st = afs_pkg::AFS_WDATA;
                    end
                end
                afs_pkg::AFS_RDATA: begin
                    if (scl_fall) begin
                        r_nxt.shreg = {r_r.shreg[6:0], 1'b0};
                        r_nxt.cnt   = r_r.cnt + 4'h1;
                        if (r_r.cnt == 4'h7) begin
                            r_nxt.oe  = 1'b0;
                            r_nxt.cnt = 4'h0;
                            r_nxt.st  = afs_pkg::AFS_RACK;
                        end else begin
                            r_nxt.oe = ~r_r.shreg[6];
                        end
                    end
                end
                afs_pkg::AFS_RACK: begin
                    if (scl_rise) begin
                        r_nxt.mack = ~sda_i;
                    end else if (scl_fall) begin
                        if (r_r.mack) begin
                            r_nxt.shreg = rd_byte;
                            r_nxt.ptr   = r_r.ptr + 8'h01;
                            r_nxt.oe    = ~rd_byte[7];
                            r_nxt.st    = afs_pkg::AFS_RDATA;
                        end else begin
                            r_nxt.st = afs_pkg::AFS_IDLE;
                        end
                    end
                end
                default: begin
                    r_nxt.st = afs_pkg::AFS_IDLE;
                    r_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r_r        <= '0;
            r_r.st     <= afs_pkg::AFS_IDLE;
            r_r.scl_q  <= 1'b1;
            r_r.sda_q  <= 1'b1;
            r_r.ctl[0] <= `AFS_GAIN_RST;
            r_r.ctl[1] <= `AFS_OCP_RST;
            r_r.ctl[2] <= `AFS_FSW_RST;
            r_r.ctl[3] <= `AFS_CTL_RST;
            r_r.ctl[4] <= `AFS_CTL_RST;
            r_r.ctl[5] <= `AFS_CTL_RST;
            r_r.ctl[6] <= `AFS_CTL_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // only the data line is ever driven, and only low
    assign sda_o       = 1'b0;
    assign sda_oe_o    = r_r.oe;
    assign osc_role_o  = r_r.strap;
    assign gain_ctl_o  = r_r.ctl[0];
    assign ocp_ctl_o   = r_r.ctl[1];
    assign fsw_ctl_o   = r_r.ctl[2];
    assign diag_ctl_o  = r_r.ctl[3];
    assign out_ctl_a_o = r_r.ctl[4];
    assign out_ctl_b_o = r_r.ctl[5];
    assign dc_thr_o    = r_r.ctl[6];
    assign fault_clr_o = clr_pulse;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_addr_mismatch_nack: assert property (
        (r_r.st == afs_pkg::AFS_ADDR && scl_fall && r_r.cnt == 4'h8
         && r_r.shreg[7:1] != {`AFS_ADDR_PREFIX, r_r.strap}
         && !start_cond && !stop_cond)
        |=> !sda_oe_o && r_r.st == afs_pkg::AFS_IDLE)
        else $error("foreign address was acknowledged");
    a_ro_write_ignored: assert property (
        (wr_commit && r_r.ptr <= `AFS_OFF_DMODE && !start_cond && !stop_cond)
        |=> r_r.ctl == $past(r_r.ctl))
        else $error("write to read-only offset changed a control");
    a_gain_write_lands: assert property (
        (wr_commit && r_r.ptr == `AFS_OFF_GAIN && !start_cond && !stop_cond)
        |=> gain_ctl_o == $past(r_r.shreg))
        else $error("gain write not stored");
    a_unused_reads_zero: assert property (
        (r_r.ptr == 8'h0e || r_r.ptr == 8'h0f) |-> rd_byte == 8'h00)
        else $error("unused offset reads nonzero");
    a_prot_evt_latch: assert property (
        chan_evt_i[0] |=> r_r.lat[0][`AFS_PROT_OC_ANY] && r_r.lat[1][0])
        else $error("overcurrent event not latched");
    a_chan_evt_latch: assert property (
        (prot_evt_i != 8'h00 || chan_evt_i != 8'h00)
        |=> (r_r.lat[0] & $past(prot_evt_i)) == $past(prot_evt_i)
            && (r_r.lat[1] & $past(chan_evt_i)) == $past(chan_evt_i))
        else $error("fault event lost");
    a_diag_evt_latch: assert property (
        (diag_a_evt_i != 8'h00 || diag_b_evt_i != 8'h00)
        |=> (r_r.lat[2] & $past(diag_a_evt_i)) == $past(diag_a_evt_i)
            && (r_r.lat[3] & $past(diag_b_evt_i)) == $past(diag_b_evt_i))
        else $error("diagnostic event lost");
    a_otw_level_code: assert property (
        (otw_level_i == 3'h3 && r_r.ptr == `AFS_OFF_LIVE)
        |-> rd_byte[7:5] == 3'h5 && rd_byte[4:0] == live_fault_i)
        else $error("warning level code wrong");
    a_latch_sticky: assert property (
        !clr_pulse |=> (r_r.lat[0] & $past(r_r.lat[0])) == $past(r_r.lat[0])
            && (r_r.lat[2] & $past(r_r.lat[2])) == $past(r_r.lat[2]))
        else $error("latched bit dropped without clear");
    a_write_ack_advance: assert property (
        (wr_commit && !start_cond && !stop_cond)
        |=> sda_oe_o && r_r.ptr == $past(r_r.ptr) + 8'h01)
        else $error("data byte not acked or pointer not advanced");
    a_role_follows_strap: assert property (
        $rose(r_r.strap_ok) |-> osc_role_o == $past(addr_sel_i))
        else $error("role not taken from strap");

endmodule : afs_regs

/* File: design/afs_map.svh */
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH

// bus address: fixed prefix then two strap bits
`define AFS_ADDR_PREFIX   5'h1b

// register offsets
`define AFS_OFF_LAT_PROT  8'h00
`define AFS_OFF_LAT_CHAN  8'h01
`define AFS_OFF_DIAG_A    8'h02
`define AFS_OFF_DIAG_B    8'h03
`define AFS_OFF_LIVE      8'h04
`define AFS_OFF_OUTST     8'h05
`define AFS_OFF_PLAY      8'h06
`define AFS_OFF_DMODE     8'h07
`define AFS_OFF_GAIN      8'h08
`define AFS_OFF_OCP       8'h09
`define AFS_OFF_FSW       8'h0a
`define AFS_OFF_DIAGCTL   8'h0b
`define AFS_OFF_OUTCTL_A  8'h0c
`define AFS_OFF_OUTCTL_B  8'h0d
`define AFS_OFF_DCTHR     8'h10
`define AFS_OFF_THERM     8'h13

// field positions
`define AFS_PROT_DC_ANY   1
`define AFS_PROT_OC_ANY   2
`define AFS_FAULT_CLR_BIT 7

// reset values
`define AFS_LAT_RST       8'h00
`define AFS_GAIN_RST      8'haa
`define AFS_OCP_RST       8'hf0
`define AFS_FSW_RST       8'h0d
`define AFS_CTL_RST       8'h00

// temperature warning codes on bits 7..5 of the live register
`define AFS_OTW_NONE      3'h0
`define AFS_OTW_WARN      3'h1
`define AFS_OTW_LVL1      3'h3
`define AFS_OTW_LVL2      3'h5
`define AFS_OTW_LVL3      3'h7

`endif

/* File: design/afs_pkg.sv */
package afs_pkg;

    typedef enum logic [3:0] {
        AFS_IDLE     = 4'h0,
        AFS_ADDR     = 4'h1,
        AFS_ACK_ADDR = 4'h2,
        AFS_SUB      = 4'h3,
        AFS_ACK_SUB  = 4'h4,
        AFS_WDATA    = 4'h5,
        AFS_ACK_WR   = 4'h6,
        AFS_RDATA    = 4'h7,
        AFS_RACK     = 4'h8
    } afs_state_t;

    typedef struct packed {
        afs_state_t       st;
        logic [3:0]       cnt;
        logic [7:0]       shreg;
        logic [7:0]       ptr;
        logic             rw;
        logic             mack;
        logic             scl_q;
        logic             sda_q;
        logic             oe;
        logic [1:0]       strap;
        logic             strap_ok;
        logic [3:0][7:0]  lat;
        logic [6:0][7:0]  ctl;
    } afs_st_t;

endpackage : afs_pkg

/* File: tb/afs_i2c_master.sv */
`timescale 1ns/1ns
module afs_i2c_master (
    // system
    input  wire logic clk_i,
    // serial bus, data line resolved by the bench
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    localparam int HALF = 6;

    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt

    // also a repeated start when entered with scl low
    task automatic start();
        sda_oe_o <= 1'b0;
        wt(HALF);
        scl_o <= 1'b1;
        wt(HALF);
        sda_oe_o <= 1'b1;
        wt(HALF);
        scl_o <= 1'b0;
        wt(HALF);
    endtask : start

    task automatic stop();
        sda_oe_o <= 1'b1;
        wt(HALF);
        scl_o <= 1'b1;
        wt(HALF);
        sda_oe_o <= 1'b0;
        wt(HALF);
    endtask : stop

    // scl is driven open loop, never read back
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o <= ~b;
        wt(HALF);
        scl_o <= 1'b1;
        wt(HALF);
        r = sda_i;
        scl_o <= 1'b0;
        wt(HALF);
    endtask : bit_io

    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put

    task automatic get(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask : get
endmodule : afs_i2c_master

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [1:0] s;
        logic [7:0] v;
        logic [7:0] o;
        logic [7:0] e;
    } afs_row_t;

    localparam logic [7:0] dev_w = {5'b11011, 2'b10, 1'b0};
    localparam logic [7:0] dev_r = dev_w | 8'h01;
    localparam logic [7:0] seq_v [6] = '{8'h55, 8'h3a, 8'h0e,
                                         8'h21, 8'h44, 8'h3c};
    localparam logic [2:0] otw_code [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    localparam logic [7:0] st_off [4] = '{8'h05, 8'h06, 8'h07, 8'h13};
    localparam logic [7:0] st_val [4] = '{8'hc1, 8'hc2, 8'hc3, 8'hc4};
    localparam afs_row_t rows [10] = '{
        '{2'd0, 8'h01, 8'h00, 8'h01},
        '{2'd0, 8'h80, 8'h00, 8'h80},
        '{2'd1, 8'h01, 8'h01, 8'h01},
        '{2'd1, 8'h08, 8'h00, 8'h04},
        '{2'd1, 8'h80, 8'h01, 8'h80},
        '{2'd1, 8'h10, 8'h00, 8'h02},
        '{2'd2, 8'h01, 8'h02, 8'h01},
        '{2'd2, 8'h80, 8'h02, 8'h80},
        '{2'd3, 8'h08, 8'h03, 8'h08},
        '{2'd3, 8'h10, 8'h03, 8'h10}};

    logic             clk, sys_rst, scl, m_oe, s_o, s_oe, a, fclr;
    logic [1:0]       strap, role;
    logic [7:0]       pe, ce, dae, dbe, ost, pm, dm, th;
    logic [4:0]       lf;
    logic [2:0]       otw;
    wire [6:0][7:0]   ctl;
    wire              sda = ~(m_oe | (s_oe & ~s_o));
    int               n_fail = 0;
    int               n_tests = 0;
    int               n_clr = 0;

    afs_regs dut_u (
        .clk_i(clk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda),
        .sda_o(s_o), .sda_oe_o(s_oe), .addr_sel_i(strap),
        .osc_role_o(role), .prot_evt_i(pe), .chan_evt_i(ce),
        .diag_a_evt_i(dae), .diag_b_evt_i(dbe), .live_fault_i(lf),
        .otw_level_i(otw), .out_state_i(ost), .play_mute_i(pm),
        .diag_mode_i(dm), .thermal_i(th), .gain_ctl_o(ctl[0]),
        .ocp_ctl_o(ctl[1]), .fsw_ctl_o(ctl[2]), .diag_ctl_o(ctl[3]),
        .out_ctl_a_o(ctl[4]), .out_ctl_b_o(ctl[5]), .dc_thr_o(ctl[6]),
        .fault_clr_o(fclr));

    afs_i2c_master mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl),
                          .sda_oe_o(m_oe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(negedge clk) begin
        if (fclr === 1'b1) n_clr++;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] off, input logic [7:0] v);
        logic k;
        mst_u.start();
        mst_u.put(dev_w, k);
        mst_u.put(off, k);
        mst_u.put(v, k);
        mst_u.stop();
    endtask : wr

    task automatic chkrd(input string nm, input logic [7:0] off,
                         input logic [7:0] e);
        logic       k;
        logic [7:0] q;
        mst_u.start();
        mst_u.put(dev_w, k);
        mst_u.put(off, k);
        mst_u.start();
        mst_u.put(dev_r, k);
        mst_u.get(1'b0, q);
        mst_u.stop();
        chk(nm, e, q);
    endtask : chkrd

    task automatic pulse(input logic [1:0] s, input logic [7:0] v);
        @(posedge clk);
        case (s)
            2'd0: pe <= v;
            2'd1: ce <= v;
            2'd2: dae <= v;
            default: dbe <= v;
        endcase
        @(posedge clk);
        {pe, ce, dae, dbe} <= '0;
    endtask : pulse

    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        strap = 2'b10;
        {pe, ce, dae, dbe} = '0;
        lf = '0;
        otw = '0;
        {ost, pm, dm, th} = {st_val[0], st_val[1], st_val[2], st_val[3]};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("role", 8'h02, {6'h00, role});
        for (int i = 0; i < 5; i++) begin
            chkrd("reset status", 8'(i), 8'h00);
        end
        chk("gain", 8'haa, ctl[0]);
        chk("ocp", 8'hf0, ctl[1]);
        chk("fsw", 8'h0d, ctl[2]);
        foreach (rows[i]) begin
            pulse(rows[i].s, rows[i].v);
            chkrd("latched", rows[i].o, rows[i].e);
            wr(8'h0d, 8'h80);
            chkrd("cleared", rows[i].o, 8'h00);
        end
        chk("clear pulses", 8'd10, 8'(n_clr));
        mst_u.start();
        mst_u.put(8'hd8, a);
        chk("foreign address ack", 8'h00, {7'h00, a});
        mst_u.stop();
        mst_u.start();
        mst_u.put(dev_w, a);
        chk("address ack", 8'h01, {7'h00, a});
        mst_u.put(8'h08, a);
        for (int i = 0; i < 6; i++) begin
            mst_u.put(seq_v[i], a);
            chk("data ack", 8'h01, {7'h00, a});
        end
        mst_u.stop();
        for (int i = 0; i < 6; i++) begin
            chk("control out", seq_v[i], ctl[i]);
            chkrd("control read", 8'h08 + 8'(i), seq_v[i]);
        end
        wr(8'h10, 8'h33);
        chk("dc threshold", 8'h33, ctl[6]);
        wr(8'h00, 8'hff);
        chkrd("read-only latch", 8'h00, 8'h00);
        wr(8'h0e, 8'h5a);
        chkrd("unused", 8'h0e, 8'h00);
        foreach (st_off[i]) begin
            wr(st_off[i], 8'h00);
            chkrd("status", st_off[i], st_val[i]);
        end
        lf <= 5'h15;
        foreach (otw_code[i]) begin
            otw <= 3'(i);
            chkrd("live", 8'h04, {otw_code[i], 5'h15});
        end
        lf <= 5'h00;
        otw <= 3'h0;
        chkrd("live idle", 8'h04, 8'h00);
        // event held across the clear: the set must win
        pe <= 8'h01;
        wr(8'h0d, 8'h80);
        pe <= 8'h00;
        chkrd("set wins", 8'h00, 8'h01);
        // second reset in mid-run brings latches and controls back
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("reset gain", 8'haa, ctl[0]);
        chk("reset clear ctl", 8'h00, ctl[5]);
        chk("reset role", 8'h02, {6'h00, role});
        chkrd("reset latch", 8'h00, 8'h00);
        stop_test();
    end
endmodule : testbench
